/* File: intc_edge.sv */
// shared constants and types of the interrupt controller, plus the pin edge detector
// assumes one system clock CLOCK and a synchronous active-high RESET
package intc_pkg;
    localparam int NUM_MASKABLE = 16; // seven pin sources and nine peripheral sources
    localparam int NUM_PINS = 7; // pin-driven sources
    localparam int NUM_EVENTS = 9; // peripheral-driven sources
    localparam logic [4:0] SRC_BREAK = 5'h10; // software break source id
    localparam logic [4:0] SRC_RESET = 5'h11; // reset source id
    localparam logic [15:0] REQ_RESET_VALUE = 16'h0000; // requests after reset
    localparam logic [15:0] ENA_RESET_VALUE = 16'h0000; // enables after reset
    localparam logic [1:0] SYNC_WARM = 2'h3; // clock cycles after reset before a pin level is trusted
    // vector low addresses, indexed by source id; entries 3 and 4 share a vector
    localparam logic [17:0][15:0] VECTOR_TABLE = {
        16'hfffc, 16'hffdc, 16'hffde, 16'hffe0, 16'hffe2, 16'hffe4,
        16'hffe6, 16'hffe8, 16'hffea, 16'hffec, 16'hffee, 16'hfff0,
        16'hfff2, 16'hfff4, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa};

    // arbiter states
    typedef enum logic {
        ST_IDLE,
        ST_PRESENT
    } arb_state_t;

    // whole state of the controller
    typedef struct packed {
        arb_state_t st; // arbiter state
        logic [15:0] req; // request bits
        logic [15:0] ena; // enable bits
        logic software_break_opcode; // break pending
        logic rst_pend; // reset vector pending
        logic [4:0] src; // presented source
        logic [15:0] vec; // presented vector
        logic mask_set; // accept pulse for the mask flag
    } ctl_t;

    // state of one pin edge detector
    typedef struct packed {
        logic sync1; // first synchroniser stage
        logic sync2; // second synchroniser stage
        logic prev; // previous synchronised level
        logic pulse; // detected edge
        logic [1:0] warm; // clock cycles since reset, saturating
    } edge_t;
endpackage

`timescale 1ns/10ps
// one pin source: two-flop synchroniser and selectable edge detector
module pin_edge_detect
    import intc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic pin,
    input wire logic rising_sel,
    output logic edge_pulse
);
    edge_t r_reg; // registered state
    edge_t r_next; // next state

    // next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.sync1 = pin; // first stage feeds only the second
        r_next.sync2 = r_reg.sync1;
        r_next.prev = r_reg.sync2;
        if (r_reg.warm != SYNC_WARM) begin // stages still hold reset zeros, a pin idling high is no edge
            r_next.warm = r_reg.warm + 2'h1;
            r_next.pulse = 1'b0;
        end else if (rising_sel) begin // rising edge chosen
            r_next.pulse = r_reg.sync2 & ~r_reg.prev;
        end else begin // falling edge chosen
            r_next.pulse = ~r_reg.sync2 & r_reg.prev;
        end
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign edge_pulse = r_reg.pulse; // one-cycle pulse from a flop
endmodule

/* File: intc_core.sv */
// interrupt request, enable and fixed-priority arbitration for the cpu core
// assumes the core pulses ACK to take a presented interrupt and pushes its own state
`timescale 1ns/10ps
module intc_core
    import intc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [6:0] PIN_IN,
    input wire logic [6:0] EDGE_RISING,
    input wire logic [8:0] EVENT_IN,
    input wire logic BREAK_EXEC,
    input wire logic MASK_FLAG,
    input wire logic ENABLE_WR,
    input wire logic [15:0] ENABLE_DATA,
    input wire logic REQUEST_WR,
    input wire logic [15:0] REQUEST_DATA,
    input wire logic ACK,
    output logic IRQ,
    output logic [4:0] SOURCE,
    output logic [15:0] VECTOR,
    output logic MASK_SET,
    output logic [15:0] REQUEST_STATE,
    output logic [15:0] ENABLE_STATE
);
    ctl_t r_reg; // registered state
    ctl_t r_next; // next state
    logic [6:0] pin_pulse; // detected pin edges
    logic [15:0] set_vec; // hardware request events
    logic [15:0] qual; // qualified maskable requests
    logic have_pick; // something to present
    logic [4:0] pick; // winning source
    logic accept; // core takes the interrupt

    // one edge detector per pin source
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            pin_edge_detect u_edge (
                .CLOCK(CLOCK),
                .RESET(RESET),
                .pin(PIN_IN[gi]),
                .rising_sel(EDGE_RISING[gi]),
                .edge_pulse(pin_pulse[gi])
            );
        end
    endgenerate

    // request bit layout in priority order, pins and events interleaved
    assign set_vec = {EVENT_IN[8], pin_pulse[6:5], EVENT_IN[7:0], pin_pulse[4:0]};
    assign qual = r_reg.req & r_reg.ena & {16{~MASK_FLAG}};
    assign accept = (r_reg.st == ST_PRESENT) && ACK;

    // fixed-priority pick: reset, then maskable by index, then break
    always_comb begin
        have_pick = 1'b0;
        pick = SRC_RESET;
        if (r_reg.rst_pend) begin // reset beats all
            have_pick = 1'b1;
            pick = SRC_RESET;
        end else if (|qual) begin // lowest index wins
            have_pick = 1'b1;
            for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
                if (qual[i]) begin
                    pick = 5'(i);
                end
            end
        end else if (r_reg.software_break_opcode) begin // break ignores mask and enables
            have_pick = 1'b1;
            pick = SRC_BREAK;
        end
    end

    // next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.mask_set = 1'b0;
        // software clear of requests, zeros clear
        if (REQUEST_WR) begin
            r_next.req = r_reg.req & REQUEST_DATA;
        end
        // software write of enables
        if (ENABLE_WR) begin
            r_next.ena = ENABLE_DATA;
        end
        unique case (r_reg.st)
            ST_IDLE: begin // wait for a winner
                if (have_pick) begin
                    r_next.st = ST_PRESENT;
                    r_next.src = pick;
                    r_next.vec = VECTOR_TABLE[pick];
                end
            end
            ST_PRESENT: begin // offered to the core
                if (ACK) begin // accepted: clear source, ask core to set mask
                    r_next.st = ST_IDLE;
                    r_next.mask_set = 1'b1;
                    if (r_reg.src == SRC_RESET) begin
                        r_next.rst_pend = 1'b0;
                    end else if (r_reg.src == SRC_BREAK) begin
                        r_next.software_break_opcode = 1'b0;
                    end else begin
                        r_next.req[r_reg.src[3:0]] = 1'b0;
                    end
                end else if (!have_pick || pick != r_reg.src) begin
                    r_next.st = ST_IDLE; // withdrawn or outranked, re-arbitrate
                end
            end
        endcase
        // hardware events win over any clear in the same cycle
        r_next.req = r_next.req | set_vec;
        if (BREAK_EXEC) begin
            r_next.software_break_opcode = 1'b1;
        end
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            r_reg.st <= ST_IDLE;
            r_reg.req <= REQ_RESET_VALUE;
            r_reg.ena <= ENA_RESET_VALUE;
            r_reg.software_break_opcode <= 1'b0;
            r_reg.rst_pend <= 1'b1;
            r_reg.src <= SRC_RESET;
            r_reg.vec <= VECTOR_TABLE[SRC_RESET];
            r_reg.mask_set <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flops
    assign IRQ = (r_reg.st == ST_PRESENT);
    assign SOURCE = r_reg.src;
    assign VECTOR = r_reg.vec;
    assign MASK_SET = r_reg.mask_set;
    assign REQUEST_STATE = r_reg.req;
    assign ENABLE_STATE = r_reg.ena;

    // helper: requests above the presented source in priority
    logic [15:0] higher_mask; // bits with lower index than SOURCE
    assign higher_mask = (16'h0001 << SOURCE[3:0]) - 16'h0001;

    // named steps of an accept
    sequence s_offer_taken;
        IRQ && ACK && (SOURCE < SRC_BREAK);
    endsequence
    sequence s_accept_done;
        MASK_SET && !IRQ;
    endsequence

    a_reset_first_vector: assert property (@(posedge CLOCK)
        $fell(RESET) |=> IRQ && SOURCE == SRC_RESET && VECTOR == 16'hfffc)
        else $error("reset vector not presented first");
    a_mask_blocks_irq: assert property (@(posedge CLOCK) disable iff (RESET)
        (r_reg.st == ST_IDLE) && MASK_FLAG && !r_reg.rst_pend && !r_reg.software_break_opcode |=> !IRQ)
        else $error("interrupt raised while masked");
    a_qualified_raises: assert property (@(posedge CLOCK) disable iff (RESET)
        (r_reg.st == ST_IDLE) && (|qual) && !r_reg.rst_pend |=> IRQ && SOURCE < SRC_BREAK)
        else $error("qualified request not raised");
    a_enable_write: assert property (@(posedge CLOCK) disable iff (RESET)
        ENABLE_WR |=> ENABLE_STATE == $past(ENABLE_DATA))
        else $error("enable write lost");
    a_request_clear: assert property (@(posedge CLOCK) disable iff (RESET)
        REQUEST_WR |=> (REQUEST_STATE & ~$past(set_vec) & ~$past(REQUEST_DATA)) == 16'h0000)
        else $error("software clear failed");
    a_no_soft_set: assert property (@(posedge CLOCK) disable iff (RESET)
        set_vec == 16'h0000 |=> (REQUEST_STATE & ~$past(REQUEST_STATE)) == 16'h0000)
        else $error("request set without event");
    a_break_unmasked: assert property (@(posedge CLOCK) disable iff (RESET)
        (r_reg.st == ST_IDLE) && r_reg.software_break_opcode && !r_reg.rst_pend && qual == 16'h0000
        |=> IRQ && SOURCE == SRC_BREAK && VECTOR == 16'hffdc)
        else $error("break not presented");
    a_priority_order: assert property (@(posedge CLOCK) disable iff (RESET)
        $rose(IRQ) && SOURCE < SRC_BREAK |-> ($past(qual) & higher_mask) == 16'h0000)
        else $error("lower priority presented first");
    a_accept_clears: assert property (@(posedge CLOCK) disable iff (RESET)
        s_offer_taken |=> s_accept_done ##0
        (REQUEST_STATE[$past(SOURCE[3:0])] == $past(set_vec[SOURCE[3:0]])))
        else $error("accept sequence wrong");
    a_edge_sets_request: assert property (@(posedge CLOCK) disable iff (RESET)
        set_vec != 16'h0000 |=> (REQUEST_STATE & $past(set_vec)) == $past(set_vec))
        else $error("event did not set request");
    a_request_sticky: assert property (@(posedge CLOCK) disable iff (RESET)
        !accept && !REQUEST_WR |=> (REQUEST_STATE & $past(REQUEST_STATE)) == $past(REQUEST_STATE))
        else $error("request dropped by itself");

    // reset, accept and withdrawal corners
    a_reset_holds_idle: assert property (@(posedge CLOCK)
        RESET |=> !IRQ && SOURCE == SRC_RESET && REQUEST_STATE == REQ_RESET_VALUE)
        else $error("state not cleared by reset");
    a_reset_not_masked: assert property (@(posedge CLOCK) disable iff (RESET)
        (r_reg.st == ST_IDLE) && r_reg.rst_pend |=> IRQ && SOURCE == SRC_RESET)
        else $error("reset vector held back");
    a_source_in_range: assert property (@(posedge CLOCK) disable iff (RESET)
        SOURCE <= SRC_RESET)
        else $error("source id out of range");
    a_mask_set_single: assert property (@(posedge CLOCK) disable iff (RESET)
        MASK_SET |=> !MASK_SET)
        else $error("mask set pulse too long");
    a_accept_drops_irq: assert property (@(posedge CLOCK) disable iff (RESET)
        accept |=> !IRQ && MASK_SET)
        else $error("irq kept after accept");
    a_break_kept: assert property (@(posedge CLOCK) disable iff (RESET)
        r_reg.software_break_opcode && !(accept && SOURCE == SRC_BREAK) |=> r_reg.software_break_opcode)
        else $error("break lost before accept");
    a_masked_withdrawn: assert property (@(posedge CLOCK) disable iff (RESET)
        IRQ && !ACK && MASK_FLAG && SOURCE < SRC_BREAK |=> !IRQ)
        else $error("masked request still offered");
endmodule

/* File: core_model.sv */
// behavioural cpu core on the far side: takes presented interrupts, keeps the mask flag
// assumes the controller's registered IRQ and MASK_SET outputs on the same clock
`timescale 1ns/10ps
module core_model (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic irq, // interrupt presented
    input wire logic mask_set, // accept pulse from the controller
    input wire logic take_on, // core willing to take interrupts
    input wire logic [3:0] delay, // wait cycles before taking
    input wire logic mask_clr, // software clears the mask flag
    output logic ack,
    output logic mask_flag
);
    logic [3:0] cnt_reg; // wait counter
    // one-cycle ack after the chosen wait, mask flag kept like the real core
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cnt_reg <= 4'h0;
            ack <= 1'b0;
            mask_flag <= 1'b1;
        end else begin
            ack <= 1'b0;
            if (irq && take_on && !ack) begin
                if (cnt_reg >= delay) begin
                    ack <= 1'b1;
                    cnt_reg <= 4'h0;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
            // accept pushes state and sets the mask
            if (mask_set || (ack && irq)) begin
                mask_flag <= 1'b1;
            end else if (mask_clr) begin
                mask_flag <= 1'b0;
            end
        end
    end
endmodule

/* File: mcu_interrupt_control_tb.sv */
// self-checking bench of the interrupt controller with a behavioural core
// assumes intc_core and core_model compiled before it
`timescale 1ns/10ps
module mcu_interrupt_control_tb
    import intc_pkg::*;
;
    logic clock = 0, reset = 1, break_exec = 0, enable_wr = 0, request_wr = 0;
    logic [6:0] pin_in = 7'h00, edge_rising = 7'h7f;
    logic [8:0] event_in = 9'h000;
    logic [15:0] enable_data = 16'h0000, request_data = 16'h0000, vector, req_state, ena_state;
    logic take_on = 0, mask_clr = 0, irq, mask_set, ack, mask_flag;
    logic [3:0] delay = 4'h0;
    logic [4:0] source;
    logic [4:0] tsrc[$]; // accepted sources
    logic [15:0] tvec[$]; // accepted vectors
    int n_errors = 0, compares = 0;
    intc_core DUT (.CLOCK(clock), .RESET(reset), .PIN_IN(pin_in), .EDGE_RISING(edge_rising),
        .EVENT_IN(event_in), .BREAK_EXEC(break_exec), .MASK_FLAG(mask_flag), .ENABLE_WR(enable_wr),
        .ENABLE_DATA(enable_data), .REQUEST_WR(request_wr), .REQUEST_DATA(request_data), .ACK(ack),
        .IRQ(irq), .SOURCE(source), .VECTOR(vector), .MASK_SET(mask_set),
        .REQUEST_STATE(req_state), .ENABLE_STATE(ena_state));
    core_model core (.CLOCK(clock), .RESET(reset), .irq(irq), .mask_set(mask_set), .take_on(take_on),
        .delay(delay), .mask_clr(mask_clr), .ack(ack), .mask_flag(mask_flag));
    always #2 clock = ~clock;
    // log each accepted interrupt
    always @(posedge clock) begin
        if (ack === 1'b1 && irq === 1'b1) begin
            tsrc.push_back(source);
            tvec.push_back(vector);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic pulse(input logic [8:0] ev, input logic software_break_opcode);
        @(posedge clock);
        event_in <= ev;
        break_exec <= software_break_opcode;
        @(posedge clock);
        event_in <= 9'h000;
        break_exec <= 1'b0;
    endtask
    task automatic wr(input logic ena, input logic [15:0] d);
        @(posedge clock);
        enable_wr <= ena;
        request_wr <= !ena;
        enable_data <= d;
        request_data <= d;
        @(posedge clock);
        enable_wr <= 1'b0;
        request_wr <= 1'b0;
    endtask
    // clear mask, let the core take one interrupt, judge source and vector
    task automatic take(input logic [4:0] exp, input logic [3:0] dly);
        @(posedge clock);
        mask_clr <= 1'b1;
        take_on <= 1'b1;
        delay <= dly;
        for (int i = 0; i < 40 && tsrc.size() == 0; i++) @(negedge clock);
        check(mask_set, 1'b1, "mask set pulse");
        @(posedge clock);
        take_on <= 1'b0;
        mask_clr <= 1'b0;
        check(tsrc.size() ? tsrc.pop_front() : 5'h1f, exp, "accepted source");
        check(tvec.size() ? tvec.pop_front() : 16'h0000, VECTOR_TABLE[exp], "vector");
    endtask
    task automatic stop_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        // reset is presented first and cannot be masked
        settle(1);
        check(irq, 1'b1, "reset irq");
        check(source, SRC_RESET, "reset source");
        check(req_state | ena_state, 16'h0000, "reset state");
        take(SRC_RESET, 4'h0);
        settle(0);
        check(mask_flag, 1'b1, "mask after accept");
        $display("done reset");
        // request held while blocked, raised once enabled and unmasked
        pulse(9'h004, 1'b0);
        @(posedge clock);
        mask_clr <= 1'b1;
        @(posedge clock);
        mask_clr <= 1'b0;
        settle(2);
        check(irq, 1'b0, "disabled source raised");
        check(req_state, 16'h0080, "request lost");
        wr(1'b1, 16'h0080);
        settle(2);
        check({irq, source, vector}, {1'b1, 5'h07, 16'hffee}, "enabled source");
        take(5'h07, 4'h3);
        settle(1);
        check({mask_flag, req_state}, {1'b1, 16'h0000}, "request after accept");
        $display("done qualify");
        // software clears requests but cannot set them, sets and clears enables
        pulse(9'h101, 1'b0);
        wr(1'b0, 16'hffff);
        settle(1);
        check(req_state, 16'h8020, "write of ones");
        wr(1'b0, 16'h7fff);
        settle(1);
        check(req_state, 16'h0020, "clear one bit");
        wr(1'b0, 16'h0000);
        wr(1'b1, 16'ha5a5);
        settle(1);
        check({req_state, ena_state}, {16'h0000, 16'ha5a5}, "enable write");
        wr(1'b1, 16'h0000);
        settle(1);
        check(ena_state, 16'h0000, "enable clear");
        $display("done software");
        // break taken though masked and nothing enabled
        pulse(9'h000, 1'b1);
        settle(3);
        check({irq, source, vector}, {1'b1, SRC_BREAK, 16'hffdc}, "break");
        take(SRC_BREAK, 4'h2);
        $display("done break");
        // all seventeen sources at once, served one by one by priority
        wr(1'b1, 16'hffff);
        @(posedge clock);
        pin_in <= 7'h7f;
        pulse(9'h1ff, 1'b1);
        settle(6);
        check(req_state, 16'hffff, "all sources");
        // mask is still set, so break is the only one offered until the core clears it
        take(SRC_BREAK, 4'h0);
        settle(2);
        check(irq, 1'b0, "masked requests held");
        for (int s = 0; s < 16; s++) take(s[4:0], s[1:0]);
        $display("done priority");
        // falling edge selected: only falling pins request
        @(posedge clock);
        edge_rising <= 7'h00;
        settle(4);
        wr(1'b0, 16'h0000);
        pin_in <= 7'h00;
        settle(6);
        check(req_state, 16'h601f, "falling edges");
        wr(1'b0, 16'h0000);
        pin_in <= 7'h7f;
        settle(6);
        check(req_state, 16'h0000, "rising ignored");
        $display("done pins");
        stop_test();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        stop_test();
    end
endmodule
